/* File: logic/timer_split.sv */
// split-mode timer 0/1 and timer 2 with wishbone register access
//
// Overview of operation
// R1: timer 1 in mode 3 holds its count as though its run bit were clear.
// R2: timer 0 in mode 3 runs its low and high bytes as two separate 8-bit counters.
// R3: the split low byte uses timer 0 select, gate, run bit and pin, and sets timer 0 overflow.
// R4: the split high byte counts clock ticks, runs on timer 1 run bit and sets timer 1 overflow.
// R5: in split mode the timer 1 interrupt comes from the high byte overflow.
// R6: timer 1 stops in its mode 3, runs out of it, and still gives a baud tick without interrupt.
// R7: the timer 1 run bit at bit 6 of the control register starts and stops timer 1.
// R8: timer 2 overflow flag is cleared only by software and never set while a clock select or clock-out is on.
// R9: a falling capture edge with external enable sets the timer 2 external flag, cleared by software.
// R10: a set uart clock select routes timer 2 overflow to that uart direction as its baud tick.
// R11: timer 2 counts only while its run bit is set.
// R12: timer 2 select picks clock ticks or falling edges of the timer 0 count pin.
// R13: in capture mode a falling capture edge copies the timer 2 count into the capture bytes.
// R14: timer 2 sets its overflow flag on 16-bit rollover unless it is a baud or clock-out source.
`timescale 1ns/1ps
`default_nettype none
module timer_split
  import timer_split_pkg::*;
(
  input  wire logic                   CLOCK_I,
  input  wire logic                   RST_I,
  input  wire timer_split_pkg::wb_req_t WB_REQ_I,
  input  wire timer_split_pkg::pins_t PINS_I,
  output logic [31:0]                 WB_DAT_O,
  output logic                        WB_ACK_O,
  output logic                        IRQ_O,
  output logic                        T1_BAUD_O,
  output logic                        U0_RX_BAUD_O,
  output logic                        U0_TX_BAUD_O,
  output logic                        U1_RX_BAUD_O,
  output logic                        U1_TX_BAUD_O,
  output logic                        T2_CLK_OUT_O
);
  import timer_split_pkg::*;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [4:0] s1_r, s2_r, s3_r, pin_r, pin_nxt;
  always_comb begin
    pin_nxt = pin_r;
    for (int i = 0; i < $bits(pins_t); i++) begin
      if (s2_r[i] == s3_r[i]) begin
        pin_nxt[i] = s3_r[i];
      end
    end
  end
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      s1_r  <= 5'h00;
      s2_r  <= 5'h00;
      s3_r  <= 5'h00;
      pin_r <= 5'h00;
    end else begin
      s1_r  <= PINS_I;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      pin_r <= pin_nxt;
    end
  end
  pins_t pin_c, pin_p;
  logic [4:0] pin_d_r;
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      pin_d_r <= 5'h00;
    end else begin
      pin_d_r <= pin_r;
    end
  end
  assign pin_c = pins_t'(pin_r);
  assign pin_p = pins_t'(pin_d_r);
  wire t0_fall  = pin_p.t0_cnt & ~pin_c.t0_cnt;
  wire t1_fall  = pin_p.t1_cnt & ~pin_c.t1_cnt;
  wire cap_fall = pin_p.cap & ~pin_c.cap;

  // ----------------------------------------
  // registers and counters
  // ----------------------------------------
  logic [7:0]  tctl_r, tctl_nxt, t2ctl_r, t2ctl_nxt, tmode_r, tmode_nxt, aux_r, aux_nxt;
  logic [15:0] t0_r, t0_nxt, t1_r, t1_nxt, t2_r, t2_nxt, cap_r, cap_nxt;
  logic [IRQ_N-1:0] ist_r, ist_nxt, imsk_r, imsk_nxt;
  logic [31:0] dat_nxt;
  logic        ack_nxt, t1b_nxt, u0r_nxt, u0t_nxt, u1r_nxt, u1t_nxt, ck_nxt;
  logic        ck_r;

  wire wr = WB_REQ_I.cyc & WB_REQ_I.stb & WB_REQ_I.we & WB_ACK_O & WB_REQ_I.sel[0];
  wire rd_any = WB_REQ_I.cyc & WB_REQ_I.stb & ~WB_ACK_O;
  wire [7:0]  wb = WB_REQ_I.dat[7:0];
  wire [15:0] ww = WB_REQ_I.dat[15:0];

  wire split0 = tmode_r[TM_MODE0 +: 2] == MODE_SPLIT;
  wire split1 = tmode_r[TM_MODE1 +: 2] == MODE_SPLIT;
  wire t0_tick = tmode_r[TM_CT0] ? t0_fall : 1'b1;
  wire t1_tick = tmode_r[TM_CT1] ? t1_fall : 1'b1;
  wire t0_run = tctl_r[TC_TR0] & (~tmode_r[TM_GATE0] | pin_c.gate0);           // [R3]
  wire t1_run = tctl_r[TC_TR1] & (~tmode_r[TM_GATE1] | pin_c.gate1) & ~split1; // [R1] [R6] [R7]
  wire t2_on  = t2ctl_r[T2_TR];                                                 // [R11]
  wire t2_tick = t2_on & (t2ctl_r[T2_CT] ? ~pin_c.t0_cnt & pin_p.t0_cnt : 1'b1); // [R12]
  wire t2_baud = t2ctl_r[T2_UART0_RX_CLOCK_SELECT] | t2ctl_r[T2_UART0_TX_CLOCK_SELECT] | aux_r[AUX_UART1_RX_CLOCK_SELECT] |
                 aux_r[AUX_UART1_TX_CLOCK_SELECT] | aux_r[AUX_OE];

  logic t0l_ov, t0h_ov, t0_ov16, t1_ov, t2_ov;
  always_comb begin
    t0_nxt = t0_r;
    t1_nxt = t1_r;
    t2_nxt = t2_r;
    cap_nxt = cap_r;
    t0l_ov = 1'b0;
    t0h_ov = 1'b0;
    t0_ov16 = 1'b0;
    t1_ov = 1'b0;
    t2_ov = 1'b0;
    if (split0) begin
      if (t0_run & t0_tick) begin                                               // [R2] [R3]
        t0_nxt[7:0] = t0_r[7:0] + 8'h01;
        t0l_ov = t0_r[7:0] == 8'hff;
      end
      if (tctl_r[TC_TR1]) begin                                                 // [R4]
        t0_nxt[15:8] = t0_r[15:8] + 8'h01;
        t0h_ov = t0_r[15:8] == 8'hff;
      end
    end else if (t0_run & t0_tick) begin
      t0_nxt = t0_r + 16'h0001;
      t0_ov16 = t0_r == 16'hffff;
    end
    if (t1_run & t1_tick) begin
      t1_nxt = t1_r + 16'h0001;
      t1_ov = t1_r == 16'hffff;
    end
    if (t2_tick) begin
      t2_nxt = t2_r + 16'h0001;
      t2_ov = t2_r == 16'hffff;
      if (t2_ov & ~t2ctl_r[T2_CPRL]) begin
        t2_nxt = cap_r;
      end
    end
    if (cap_fall & t2ctl_r[T2_EXEN]) begin
      if (t2ctl_r[T2_CPRL]) begin
        cap_nxt = t2_r;                                                         // [R13]
      end else begin
        t2_nxt = cap_r;
      end
    end
    if (wr && WB_REQ_I.adr == T0CNT_OFF) t0_nxt = ww;
    if (wr && WB_REQ_I.adr == T1CNT_OFF) t1_nxt = ww;
    if (wr && WB_REQ_I.adr == T2CNT_OFF) t2_nxt = ww;
    if (wr && WB_REQ_I.adr == T2CAP_OFF) cap_nxt = ww;
  end

  // ----------------------------------------
  // control, flags and bus
  // ----------------------------------------
  wire set_tf0 = t0l_ov | t0_ov16;                                              // [R3]
  wire set_tf1 = split0 ? t0h_ov : t1_ov;                                       // [R4] [R5]
  wire set_tf2 = t2_ov & ~t2_baud;                                              // [R8] [R14]
  wire set_exf = cap_fall & t2ctl_r[T2_EXEN];                                   // [R9]
  wire [IRQ_N-1:0] ev = {set_exf, set_tf2, set_tf1, set_tf0};

  always_comb begin
    tctl_nxt = tctl_r;
    t2ctl_nxt = t2ctl_r;
    tmode_nxt = tmode_r;
    aux_nxt = aux_r;
    imsk_nxt = imsk_r;
    ist_nxt = ist_r;
    dat_nxt = 32'h0000_0000;
    ack_nxt = rd_any;
    if (wr) begin
      case (WB_REQ_I.adr)
        TCTL_OFF: tctl_nxt = wb;                                                // [R7]
        T2CTL_OFF: t2ctl_nxt = wb;
        TMODE_OFF: tmode_nxt = wb;
        T2AUX_OFF: aux_nxt = wb;
        IRQ_MSK_OFF: imsk_nxt = wb[IRQ_N-1:0];
        IRQ_ST_OFF: ist_nxt = ist_r & ~wb[IRQ_N-1:0];
        default: ;
      endcase
    end
    // hardware set wins over a software clear in the same cycle
    if (set_tf0) tctl_nxt[TC_TF0] = 1'b1;
    if (set_tf1) tctl_nxt[TC_TF1] = 1'b1;                                       // [R5]
    if (set_tf2) t2ctl_nxt[T2_TF2] = 1'b1;                                      // [R8]
    if (set_exf) t2ctl_nxt[T2_T2_EXTERNAL_FLAG] = 1'b1;                                     // [R9]
    ist_nxt = ist_nxt | ev;
    if (rd_any) begin
      case (WB_REQ_I.adr)
        TCTL_OFF: dat_nxt = {24'h0, tctl_r};
        T2CTL_OFF: dat_nxt = {24'h0, t2ctl_r};
        TMODE_OFF: dat_nxt = {24'h0, tmode_r};
        T0CNT_OFF: dat_nxt = {16'h0, t0_r};
        T1CNT_OFF: dat_nxt = {16'h0, t1_r};
        T2CNT_OFF: dat_nxt = {16'h0, t2_r};
        T2CAP_OFF: dat_nxt = {16'h0, cap_r};
        T2AUX_OFF: dat_nxt = {24'h0, aux_r};
        IRQ_ST_OFF: dat_nxt = {28'h0, ist_r};
        IRQ_MSK_OFF: dat_nxt = {28'h0, imsk_r};
        default: dat_nxt = 32'h0000_0000;
      endcase
    end
    t1b_nxt = t1_ov & ~split1;                                                  // [R6]
    u0r_nxt = t2_ov & t2ctl_r[T2_UART0_RX_CLOCK_SELECT];                                        // [R10]
    u0t_nxt = t2_ov & t2ctl_r[T2_UART0_TX_CLOCK_SELECT];                                        // [R10]
    u1r_nxt = t2_ov & aux_r[AUX_UART1_RX_CLOCK_SELECT];                                         // [R10]
    u1t_nxt = t2_ov & aux_r[AUX_UART1_TX_CLOCK_SELECT];                                         // [R10]
    ck_nxt = ck_r ^ (t2_ov & aux_r[AUX_OE] & ~t2ctl_r[T2_CT]);
  end

  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      tctl_r <= RST_BYTE;
      t2ctl_r <= RST_BYTE;
      tmode_r <= RST_BYTE;
      aux_r <= RST_BYTE;
      t0_r <= 16'h0000;
      t1_r <= 16'h0000;
      t2_r <= 16'h0000;
      cap_r <= 16'h0000;
      ist_r <= '0;
      imsk_r <= '0;
      ck_r <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
      WB_ACK_O <= 1'b0;
      IRQ_O <= 1'b0;
      T1_BAUD_O <= 1'b0;
      U0_RX_BAUD_O <= 1'b0;
      U0_TX_BAUD_O <= 1'b0;
      U1_RX_BAUD_O <= 1'b0;
      U1_TX_BAUD_O <= 1'b0;
      T2_CLK_OUT_O <= 1'b0;
    end else begin
      tctl_r <= tctl_nxt;
      t2ctl_r <= t2ctl_nxt;
      tmode_r <= tmode_nxt;
      aux_r <= aux_nxt;
      t0_r <= t0_nxt;
      t1_r <= t1_nxt;
      t2_r <= t2_nxt;
      cap_r <= cap_nxt;
      ist_r <= ist_nxt;
      imsk_r <= imsk_nxt;
      ck_r <= ck_nxt;
      WB_DAT_O <= dat_nxt;
      WB_ACK_O <= ack_nxt;
      IRQ_O <= |(ist_nxt & imsk_nxt);
      T1_BAUD_O <= t1b_nxt;
      U0_RX_BAUD_O <= u0r_nxt;
      U0_TX_BAUD_O <= u0t_nxt;
      U1_RX_BAUD_O <= u1r_nxt;
      U1_TX_BAUD_O <= u1t_nxt;
      T2_CLK_OUT_O <= ck_nxt;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);

  t1_hold_a: assert property (split1 && !wr |=> t1_r == $past(t1_r)) // [R1]
    else $error("timer 1 moved in mode 3");
  split_low_a: assert property (split0 && !wr && !t0_run |=> t0_r[7:0] == $past(t0_r[7:0])) // [R2]
    else $error("split low byte moved while stopped");
  low_flag_a: assert property (t0l_ov |=> tctl_r[TC_TF0]) // [R3]
    else $error("low byte overflow lost");
  high_cnt_a: assert property (split0 && tctl_r[TC_TR1] && !wr // [R4]
    |=> t0_r[15:8] == $past(t0_r[15:8]) + 8'h01)
    else $error("split high byte did not count");
  high_flag_a: assert property (t0h_ov |=> tctl_r[TC_TF1] && ist_r[IRQ_TF1]) // [R5]
    else $error("high byte overflow did not reach timer 1 flag");
  t1_baud_a: assert property (split1 |=> !T1_BAUD_O) // [R6]
    else $error("baud tick while timer 1 held");
  t1_run_a: assert property (!tctl_r[TC_TR1] && !wr |=> t1_r == $past(t1_r)) // [R7]
    else $error("timer 1 ran with run bit clear");
  tf2_block_a: assert property (t2_baud && !wr && !t2ctl_r[T2_TF2] |=> !t2ctl_r[T2_TF2]) // [R8]
    else $error("timer 2 flag set while baud source");
  exf_set_a: assert property (set_exf |=> t2ctl_r[T2_T2_EXTERNAL_FLAG]) // [R9]
    else $error("external flag missed");
  u0_baud_a: assert property (t2_ov && t2ctl_r[T2_UART0_RX_CLOCK_SELECT] |=> U0_RX_BAUD_O) // [R10]
    else $error("uart0 receive tick missing");
  t2_stop_a: assert property (!t2_on && !wr && !set_exf |=> t2_r == $past(t2_r)) // [R11]
    else $error("timer 2 ran while stopped");
  cap_copy_a: assert property (set_exf && t2ctl_r[T2_CPRL] && !wr |=> cap_r == $past(t2_r)) // [R13]
    else $error("capture did not copy count");
  sequence ov_no_baud_s;
    t2_ov && !t2_baud;
  endsequence
  tf2_set_a: assert property (ov_no_baud_s |=> t2ctl_r[T2_TF2]) // [R14]
    else $error("timer 2 overflow flag missed");
  t2_count_a: assert property (t2_tick && !t2_ov && !set_exf && !wr // [R12]
    |=> t2_r == $past(t2_r) + 16'h0001)
    else $error("timer 2 missed a count");
  ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O) // bus acknowledge lasts one cycle
    else $error("acknowledge held beyond one cycle");
  t1_quiet_a: assert property (split0 && t1_ov && !t0h_ov && !wr && !tctl_r[TC_TF1] // [R6]
    |=> !tctl_r[TC_TF1])
    else $error("timer 1 flagged while timer 0 split");
  u0_tx_a: assert property (t2_ov && t2ctl_r[T2_UART0_TX_CLOCK_SELECT] |=> U0_TX_BAUD_O) // [R10]
    else $error("uart0 transmit tick missing");
  u1_tx_a: assert property (t2_ov && aux_r[AUX_UART1_TX_CLOCK_SELECT] |=> U1_TX_BAUD_O) // [R10]
    else $error("uart1 transmit tick missing");
endmodule
`default_nettype wire

/* File: pkg/timer_split_pkg.sv */
// package: register map, field positions and shared types of the split-mode timer block
package timer_split_pkg;
  // register offsets (byte addresses on the wishbone bus)
  localparam logic [11:0] TCTL_OFF    = 12'h410;
  localparam logic [11:0] T2CTL_OFF   = 12'h414;
  localparam logic [11:0] TMODE_OFF   = 12'h418;
  localparam logic [11:0] T0CNT_OFF   = 12'h41c;
  localparam logic [11:0] T1CNT_OFF   = 12'h420;
  localparam logic [11:0] T2CNT_OFF   = 12'h424;
  localparam logic [11:0] T2CAP_OFF   = 12'h428;
  localparam logic [11:0] T2AUX_OFF   = 12'h42c;
  localparam logic [11:0] IRQ_ST_OFF  = 12'h430;
  localparam logic [11:0] IRQ_MSK_OFF = 12'h434;
  // timer_run_and_flag_control fields
  localparam int TC_TF1 = 7;
  localparam int TC_TR1 = 6;
  localparam int TC_TF0 = 5;
  localparam int TC_TR0 = 4;
  // timer2_control fields
  localparam int T2_TF2   = 7;
  localparam int T2_T2_EXTERNAL_FLAG  = 6;
  localparam int T2_UART0_RX_CLOCK_SELECT = 5;
  localparam int T2_UART0_TX_CLOCK_SELECT = 4;
  localparam int T2_EXEN  = 3;
  localparam int T2_TR    = 2;
  localparam int T2_CT    = 1;
  localparam int T2_CPRL  = 0;
  // auxiliary control fields
  localparam int AUX_UART1_RX_CLOCK_SELECT = 0;
  localparam int AUX_UART1_TX_CLOCK_SELECT = 1;
  localparam int AUX_OE    = 2;
  // mode register: [7]gate1 [6]ct1 [5:4]mode1 [3]gate0 [2]ct0 [1:0]mode0
  localparam int TM_MODE0 = 0;
  localparam int TM_CT0   = 2;
  localparam int TM_GATE0 = 3;
  localparam int TM_MODE1 = 4;
  localparam int TM_CT1   = 6;
  localparam int TM_GATE1 = 7;
  localparam logic [1:0] MODE_SPLIT = 2'h3;
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam int IRQ_N = 4;
  localparam int IRQ_TF0 = 0;
  localparam int IRQ_TF1 = 1;
  localparam int IRQ_TF2 = 2;
  localparam int IRQ_T2_EXTERNAL_FLAG = 3;
  typedef struct packed {
    logic [11:0] adr;
    logic [31:0] dat;
    logic        we;
    logic [3:0]  sel;
    logic        stb;
    logic        cyc;
  } wb_req_t;
  typedef struct packed {
    logic t0_cnt;
    logic t1_cnt;
    logic gate0;
    logic gate1;
    logic cap;
  } pins_t;
endpackage

/* File: tb/pin_model.sv */
// pin model: count, gate and capture pins idle high, pulled low on request
`timescale 1ns/1ps
`default_nettype none
module pin_model
(
  input  wire logic                   CLOCK_I,
  input  wire logic                   RST_I,
  input  wire timer_split_pkg::pins_t PULSE_I,
  output var  timer_split_pkg::pins_t PINS_O
);
  import timer_split_pkg::*;
  logic [2:0] low_r   [5];
  logic [2:0] low_nxt [5];
  // a requested pin stays low four cycles, long enough for the synchroniser
  always_comb begin
    for (int k = 0; k < 5; k++) begin
      low_nxt[k] = PULSE_I[k] ? 3'h4 : ((low_r[k] != 3'h0) ? low_r[k] - 3'h1 : 3'h0);
      PINS_O[k]  = (low_r[k] == 3'h0);
    end
  end
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    for (int k = 0; k < 5; k++) begin
      low_r[k] <= RST_I ? 3'h0 : low_nxt[k];
    end
  end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// testbench: register table, reset, split mode and timer 2 flags
`timescale 1ns/1ps
`default_nettype none
module tb;
  import timer_split_pkg::*;
  logic        CLOCK_I     = 1'b0;
  logic        RST_I       = 1'b1;
  wb_req_t     req         = '0;
  pins_t       pulse       = '0;
  pins_t       pins;
  logic [31:0] dat_o;
  logic        ack;
  logic        irq;
  logic [5:0]  outs;
  int          tally [6]   = '{default: 0};
  int          base [6]    = '{default: 0};
  int          err_total   = 0;
  int          comparisons = 0;
  int          b;
  logic [31:0] q;
  logic [31:0] h;
  logic [43:0] rows [6]    = '{{TMODE_OFF, 16'h00a5, 16'h00a5}, {IRQ_MSK_OFF, 16'h000f, 16'h000f},
                               {T2AUX_OFF, 16'h0007, 16'h0007}, {T2CAP_OFF, 16'hbeef, 16'hbeef},
                               {12'h440, 16'h00ff, 16'h0000}, {TCTL_OFF, 16'h000f, 16'h000f}};
  timer_split timer_split_i (.CLOCK_I(CLOCK_I), .RST_I(RST_I), .WB_REQ_I(req), .PINS_I(pins),
    .WB_DAT_O(dat_o), .WB_ACK_O(ack), .IRQ_O(irq), .T1_BAUD_O(outs[5]), .U0_RX_BAUD_O(outs[4]),
    .U0_TX_BAUD_O(outs[3]), .U1_RX_BAUD_O(outs[2]), .U1_TX_BAUD_O(outs[1]),
    .T2_CLK_OUT_O(outs[0]));
  pin_model pin_model_i (.CLOCK_I(CLOCK_I), .RST_I(RST_I), .PULSE_I(pulse), .PINS_O(pins));
  always #4 CLOCK_I = ~CLOCK_I;
  always @(posedge CLOCK_I) begin
    for (int k = 0; k < 6; k++) tally[k] += outs[k];
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge CLOCK_I);
    req <= '{adr: a, dat: d, we: w, sel: 4'hf, stb: 1'b1, cyc: 1'b1};
    do begin
      @(posedge CLOCK_I);
    end while (ack !== 1'b1);
    q = dat_o;
    req <= '0;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge CLOCK_I);
  endtask
  task automatic pulse_pin(input int k);
    pulse[k] <= 1'b1;
    @(posedge CLOCK_I);
    pulse <= '0;
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #100000;
    err_total++;
    test_done;
  end
  initial begin
    tick(2);
    RST_I <= 1'b0;
    foreach (rows[i]) begin
      bus(1'b1, rows[i][43:32], {16'h0, rows[i][31:16]});
      bus(1'b0, rows[i][43:32], 32'h0);
      chk(q, {16'h0, rows[i][15:0]});
    end
    $display("test table ended");
    RST_I <= 1'b1;
    tick(2);
    RST_I <= 1'b0;
    bus(1'b0, TCTL_OFF, 32'h0);
    chk(q, 32'h0);
    chk(irq, 32'h0);
    $display("test reset ended");
    bus(1'b1, IRQ_MSK_OFF, 32'h2);
    bus(1'b1, TMODE_OFF, 32'h33);
    bus(1'b1, T1CNT_OFF, 32'h1234);
    bus(1'b1, T0CNT_OFF, 32'hf0f8);
    b = tally[5];
    bus(1'b1, TCTL_OFF, 32'h50);
    tick(40);
    bus(1'b0, TCTL_OFF, 32'h0);
    chk(q, 32'hf0);
    chk(irq, 32'h1);
    bus(1'b0, IRQ_ST_OFF, 32'h0);
    chk(q, 32'h3);
    bus(1'b0, T1CNT_OFF, 32'h0);
    chk(q, 32'h1234);
    chk(tally[5] == b, 32'h1);
    bus(1'b1, TCTL_OFF, 32'h10);
    bus(1'b0, T0CNT_OFF, 32'h0);
    h = q;
    tick(10);
    bus(1'b0, T0CNT_OFF, 32'h0);
    chk(q[15:8], h[15:8]);
    chk(q[7:0] != h[7:0], 32'h1);
    bus(1'b1, TCTL_OFF, 32'h0);
    bus(1'b1, IRQ_ST_OFF, 32'hf);
    tick(2);
    chk(irq, 32'h0);
    bus(1'b1, TMODE_OFF, 32'h03);
    bus(1'b1, T1CNT_OFF, 32'hfff0);
    b = tally[5];
    bus(1'b1, TCTL_OFF, 32'h40);
    tick(40);
    chk(tally[5] != b, 32'h1);
    bus(1'b1, TCTL_OFF, 32'h0);
    bus(1'b0, T1CNT_OFF, 32'h0);
    h = q;
    tick(5);
    bus(1'b0, T1CNT_OFF, 32'h0);
    chk(q, h);
    $display("test split ended");
    bus(1'b1, T2CNT_OFF, 32'hfff8);
    bus(1'b1, T2AUX_OFF, 32'h7);
    foreach (base[k]) base[k] = tally[k];
    bus(1'b1, T2CTL_OFF, 32'h34);
    tick(30);
    bus(1'b0, T2CTL_OFF, 32'h0);
    chk(q[7], 32'h0);
    for (int k = 0; k < 5; k++) chk(tally[k] != base[k], 32'h1);
    bus(1'b1, T2AUX_OFF, 32'h0);
    bus(1'b1, T2CTL_OFF, 32'h0);
    bus(1'b1, T2CNT_OFF, 32'hfff8);
    bus(1'b1, T2CTL_OFF, 32'h04);
    tick(30);
    bus(1'b0, T2CTL_OFF, 32'h0);
    chk(q, 32'h84);
    bus(1'b1, T2CTL_OFF, 32'h0);
    bus(1'b0, T2CTL_OFF, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, T2CNT_OFF, 32'h5a5a);
    bus(1'b1, T2CTL_OFF, 32'h09);
    pulse_pin(0);
    tick(20);
    bus(1'b0, T2CAP_OFF, 32'h0);
    chk(q, 32'h5a5a);
    bus(1'b0, T2CTL_OFF, 32'h0);
    chk(q, 32'h49);
    bus(1'b0, T2CNT_OFF, 32'h0);
    chk(q, 32'h5a5a);
    bus(1'b1, T2CTL_OFF, 32'h06);
    tick(10);
    bus(1'b0, T2CNT_OFF, 32'h0);
    chk(q, 32'h5a5a);
    pulse_pin(4);
    tick(20);
    bus(1'b0, T2CNT_OFF, 32'h0);
    chk(q, 32'h5a5b);
    $display("test timer2 ended");
    test_done;
  end
endmodule
`default_nettype wire
